// File: rtl/sla_pkg.sv
// package for the serial line arbiter timer
// assumes a single 10 MHz bus clock and a plain strobe register port
`default_nettype none
package sla_pkg;
  localparam logic [1:0] ADDR_W          = 2'h2;
  localparam logic [1:0] OFS_CONTROL     = 2'h0;
  localparam logic [1:0] OFS_COUNT_LOW   = 2'h1;
  localparam logic [1:0] OFS_STATUS      = 2'h2;
  // control register fields
  localparam int         CTL_MODE_LO     = 0;
  localparam int         CTL_MODE_HI     = 1;
  localparam int         CTL_ACLK        = 2;
  // status register fields
  localparam int         ST_TOP          = 0;
  localparam int         ST_OVFL         = 1;
  localparam int         ST_RUN          = 2;
  localparam int         ST_DONE         = 3;
  localparam int         ST_LOST         = 4;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [8:0] RST_COUNT       = 9'h000;
  localparam logic [1:0] DIV_LAST        = 2'h3;
  localparam logic [8:0] SAMPLE_BUS      = 9'h038;
  localparam logic [8:0] SAMPLE_PRE      = 9'h008;
  localparam logic [1:0] MODE_IDLE       = 2'h0;
  localparam logic [1:0] MODE_MEASURE    = 2'h1;
  localparam logic [1:0] MODE_ARB        = 2'h2;
  typedef enum logic [1:0] {sla_idle, sla_wait, sla_count, sla_held} sla_state_e;
endpackage
`default_nettype wire

// File: rtl/sla_timer.sv
// serial line arbiter timer: baud/break measurement and bus arbitration
// assumes rx, tx and prescaler tick synchronous to clock; rx synchronised here anyway
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - low eight bits of nine-bit counter readable, cleared by reset
// - any control write clears the counter low bits
// - mode 00 holds counter reset and idle
// - clock select 0: count once every four bus clocks
// - measure, select 0: start on rx falling edge, stop on next
// - running flag while counting; done flag on second falling edge in select 0, on rx rising edge in select 1
// - clock select 1: count at quarter of prescaler tick rate
// - measure, select 1: start when rx seen low
// - measure, select 1: rx already low at enable starts counting immediately
// - measure, select 1: stop on next rx rising edge
// - mode 10 arbitration, restart counter on each tx rising edge
// - arbitration samples rx at count 38 hex or 08 hex
// - rx low at the sample sets arbitration lost
// - while lost is set, tx pin forced high
// - tx low before rx seen low resets counter until next tx rise
// - mode field 00 idle, 01 measure, 10 arbitrate, 11 unused
// - lost flag cleared by writing zero to upper mode bit, or reset
// - done flag cleared by any control write or reset
// - overflow flag set on counter wrap, cleared by control write or reset
module sla_timer
  import sla_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [1:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [7:0]   rdata,
  input  wire logic         rx_pin,
  input  wire logic         serial_tx_internal,
  input  wire logic         prescaler_tick,
  output logic              tx_pin
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] arbiter_mode_sel;
  logic       aclk_sel;
  logic [8:0] count;
  logic       count_overflow_flag;
  logic       measure_done_flag;
  logic       arbitration_lost_flag;
  logic [1:0] div;
  logic       rx_meta;
  logic       rx_s;
  logic       rx_d;
  logic       tx_d;
  logic       rx_low_seen;
  sla_state_e state;
  sla_state_e next_state;

  wire ctl_wr   = wr && (addr == OFS_CONTROL);
  wire rx_fall  = rx_d && !rx_s;
  wire rx_rise  = !rx_d && rx_s;
  wire tx_rise  = !tx_d && serial_tx_internal;
  wire src_tick = aclk_sel ? prescaler_tick : 1'b1;
  wire step     = src_tick && (div == DIV_LAST);
  wire running  = (state == sla_count);
  wire [8:0] sample_at = aclk_sel ? SAMPLE_PRE : SAMPLE_BUS;
  wire sample_hit = (arbiter_mode_sel == MODE_ARB) && running && step
                    && (count == sample_at - 9'h001);
  wire tx_abort = (arbiter_mode_sel == MODE_ARB) && !serial_tx_internal && !rx_low_seen;
  wire [7:0] status_byte = {3'h0, arbitration_lost_flag, measure_done_flag, running,
                            count_overflow_flag, count[8]};
  wire [7:0] ctl_byte = {5'h00, aclk_sel, arbiter_mode_sel};

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser, first flop read only by the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
      rx_d    <= 1'b1;
      tx_d    <= 1'b0;
    end else begin
      rx_meta <= rx_pin;
      rx_s    <= rx_meta;
      rx_d    <= rx_s;
      tx_d    <= serial_tx_internal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arbiter_mode_sel <= MODE_IDLE;
      aclk_sel         <= 1'b0;
    end else if (ctl_wr) begin
      arbiter_mode_sel <= wdata[CTL_MODE_HI:CTL_MODE_LO];
      aclk_sel         <= wdata[CTL_ACLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      sla_idle: begin
        if (arbiter_mode_sel == MODE_MEASURE) begin
          next_state = sla_wait;
        end else if (arbiter_mode_sel == MODE_ARB) begin
          next_state = sla_wait;
        end
      end
      sla_wait: begin
        if (arbiter_mode_sel == MODE_MEASURE) begin
          if (aclk_sel ? !rx_s : rx_fall) begin
            next_state = sla_count;
          end
        end else if (tx_rise) begin
          next_state = sla_count;
        end
      end
      sla_count: begin
        if (arbiter_mode_sel == MODE_MEASURE) begin
          if (aclk_sel ? rx_rise : rx_fall) begin
            next_state = sla_held;
          end
        end else if (tx_abort) begin
          next_state = sla_wait;
        end
      end
      sla_held: begin
        if (arbiter_mode_sel == MODE_ARB && tx_rise) begin
          next_state = sla_count;
        end
      end
      default: next_state = sla_idle;
    endcase
    if (arbiter_mode_sel == MODE_IDLE || arbiter_mode_sel == 2'h3) begin
      next_state = sla_idle;
    end
    if (ctl_wr) begin
      next_state = sla_idle;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= sla_idle;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, prescale and flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div                 <= 2'h0;
      count               <= RST_COUNT;
      count_overflow_flag <= 1'b0;
    end else begin
      if (state != sla_count) begin
        div <= 2'h0;
      end else if (src_tick) begin
        div <= div + 2'h1;
      end
      if (ctl_wr || state == sla_idle) begin
        count               <= RST_COUNT;
        count_overflow_flag <= 1'b0;
      end else if (arbiter_mode_sel == MODE_ARB && (tx_rise || tx_abort)) begin
        count <= RST_COUNT;
      end else if (running && step) begin
        count <= count + 9'h001;
        if (count == 9'h1ff) begin
          count_overflow_flag <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      measure_done_flag <= 1'b0;
      rx_low_seen       <= 1'b0;
    end else begin
      if (state == sla_count && next_state == sla_held) begin
        measure_done_flag <= 1'b1;
      end else if (ctl_wr) begin
        measure_done_flag <= 1'b0;
      end
      if (tx_rise || state != sla_count) begin
        rx_low_seen <= 1'b0;
      end else if (!rx_s) begin
        rx_low_seen <= 1'b1;
      end
    end
  end

  // set wins over the clearing write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arbitration_lost_flag <= 1'b0;
    end else if (sample_hit && !rx_s) begin
      arbitration_lost_flag <= 1'b1;
    end else if (ctl_wr && !wdata[CTL_MODE_HI]) begin
      arbitration_lost_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire next_tx = (sample_hit && !rx_s) || arbitration_lost_flag
                 ? 1'b1 : serial_tx_internal;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_pin <= 1'b1;
      rdata  <= RST_BYTE;
    end else begin
      tx_pin <= next_tx;
      if (!rd) begin
        rdata <= RST_BYTE;
      end else if (addr == OFS_CONTROL) begin
        rdata <= ctl_byte;
      end else if (addr == OFS_COUNT_LOW) begin
        rdata <= count[7:0];
      end else if (addr == OFS_STATUS) begin
        rdata <= status_byte;
      end else begin
        rdata <= RST_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_idle_holds: assert property (@(posedge clock) disable iff (!nrst)
    (arbiter_mode_sel == MODE_IDLE) |=> (count == RST_COUNT) && !running)
    else $error("idle mode did not hold counter");
  a_write_clears: assert property (@(posedge clock) disable iff (!nrst)
    ctl_wr |=> (count == RST_COUNT) && !count_overflow_flag)
    else $error("control write did not clear counter");
  a_lost_forces_tx: assert property (@(posedge clock) disable iff (!nrst)
    arbitration_lost_flag |=> tx_pin)
    else $error("tx not forced high while lost");
  a_lost_sets: assert property (@(posedge clock) disable iff (!nrst)
    (sample_hit && !rx_s) |=> arbitration_lost_flag)
    else $error("lost flag not set at sample");
  a_bus_step: assert property (@(posedge clock) disable iff (!nrst)
    (running && !aclk_sel && $past(running) && !ctl_wr && !tx_abort && !tx_rise
     && arbiter_mode_sel == MODE_MEASURE && step) |=> (count == $past(count) + 9'h001))
    else $error("counter step wrong");
  a_done_on_stop: assert property (@(posedge clock) disable iff (!nrst)
    (state == sla_count && next_state == sla_held) |=> measure_done_flag && !running)
    else $error("done flag not set on stop");
  a_held_count: assert property (@(posedge clock) disable iff (!nrst)
    (state == sla_held && !ctl_wr && !tx_rise) |=> $stable(count))
    else $error("count changed while held");
  a_lost_clear: assert property (@(posedge clock) disable iff (!nrst)
    (ctl_wr && !wdata[CTL_MODE_HI] && !sample_hit) |=> !arbitration_lost_flag)
    else $error("lost flag not cleared");

  ////////////////////////////////////////////////////////////////////////////
  // checking aid: clocks since the last count step, saturating
  logic [3:0] gap;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap <= 4'h0;
    end else if (!running || step) begin
      gap <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
  a_bus_gap: assert property (@(posedge clock) disable iff (!nrst)
    (running && !aclk_sel) |-> (gap <= 4'h3))
    else $error("bus clock step gap too long");
  a_bus_rate: assert property (@(posedge clock) disable iff (!nrst)
    (running && !aclk_sel && gap == 4'h3) |-> step)
    else $error("bus clock step missing");
  a_pre_rate: assert property (@(posedge clock) disable iff (!nrst)
    (running && aclk_sel && step) |-> prescaler_tick)
    else $error("prescaler step without tick");
  a_wrap_ovfl: assert property (@(posedge clock) disable iff (!nrst)
    (running && step && count == 9'h1ff && !ctl_wr
     && !(arbiter_mode_sel == MODE_ARB && (tx_rise || tx_abort))) |=> count_overflow_flag)
    else $error("overflow flag not set on wrap");
  a_ovfl_sticky: assert property (@(posedge clock) disable iff (!nrst)
    (count_overflow_flag && !ctl_wr) |=> count_overflow_flag)
    else $error("overflow flag dropped");
  a_done_clear: assert property (@(posedge clock) disable iff (!nrst)
    ctl_wr |=> !measure_done_flag)
    else $error("done flag not cleared by write");
  a_done_sticky: assert property (@(posedge clock) disable iff (!nrst)
    (measure_done_flag && !ctl_wr) |=> measure_done_flag)
    else $error("done flag dropped");
  a_fall_start: assert property (@(posedge clock) disable iff (!nrst)
    (state == sla_wait && arbiter_mode_sel == MODE_MEASURE && !aclk_sel && rx_fall
     && !ctl_wr) |=> running)
    else $error("falling edge did not start counter");
  a_fall_stop: assert property (@(posedge clock) disable iff (!nrst)
    (running && arbiter_mode_sel == MODE_MEASURE && !aclk_sel && rx_fall && !ctl_wr)
    |=> (state == sla_held))
    else $error("falling edge did not stop counter");
  a_low_start: assert property (@(posedge clock) disable iff (!nrst)
    (state == sla_wait && arbiter_mode_sel == MODE_MEASURE && aclk_sel && !rx_s
     && !ctl_wr) |=> running)
    else $error("low level did not start counter");
  a_rise_stop: assert property (@(posedge clock) disable iff (!nrst)
    (running && arbiter_mode_sel == MODE_MEASURE && aclk_sel && rx_rise && !ctl_wr)
    |=> (state == sla_held))
    else $error("rising edge did not stop counter");
  a_tx_restart: assert property (@(posedge clock) disable iff (!nrst)
    (arbiter_mode_sel == MODE_ARB && tx_rise && !ctl_wr && state != sla_idle)
    |=> (count == RST_COUNT) && running)
    else $error("tx rise did not restart counter");
  a_sample_point: assert property (@(posedge clock) disable iff (!nrst)
    (sample_hit && !ctl_wr && !tx_rise && !tx_abort)
    |=> (count == $past(sample_at)))
    else $error("sample not at the set count");
  a_no_early_lost: assert property (@(posedge clock) disable iff (!nrst)
    (!arbitration_lost_flag && !(sample_hit && !rx_s)) |=> !arbitration_lost_flag)
    else $error("lost flag set outside sample");
  a_abort_resets: assert property (@(posedge clock) disable iff (!nrst)
    tx_abort |=> (count == RST_COUNT) && !running)
    else $error("early tx low did not reset counter");
  a_reserved_idle: assert property (@(posedge clock) disable iff (!nrst)
    (arbiter_mode_sel == 2'h3) |=> (state == sla_idle))
    else $error("reserved mode not idle");
  a_tx_follows: assert property (@(posedge clock) disable iff (!nrst)
    (!arbitration_lost_flag && !(sample_hit && !rx_s)) |=> (tx_pin == $past(serial_tx_internal)))
    else $error("tx pin not following transmit signal");
  a_rdata_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !rd |=> (rdata == RST_BYTE))
    else $error("read data not zero without read");
  a_count_read: assert property (@(posedge clock) disable iff (!nrst)
    (rd && addr == OFS_COUNT_LOW) |=> (rdata == $past(count[7:0])))
    else $error("count read wrong");
  a_ctl_read: assert property (@(posedge clock) disable iff (!nrst)
    (rd && addr == OFS_CONTROL) |=> (rdata == $past(ctl_byte)))
    else $error("control read wrong");
  a_status_read: assert property (@(posedge clock) disable iff (!nrst)
    (rd && addr == OFS_STATUS) |=> (rdata == $past(status_byte)))
    else $error("status read wrong");
  a_spare_read: assert property (@(posedge clock) disable iff (!nrst)
    (rd && addr == 2'h3) |=> (rdata == RST_BYTE))
    else $error("spare index read not zero");
  a_mode_load: assert property (@(posedge clock) disable iff (!nrst)
    ctl_wr |=> (arbiter_mode_sel == $past(wdata[CTL_MODE_HI:CTL_MODE_LO])))
    else $error("mode field not loaded");
  a_rx_sync: assert property (@(posedge clock) disable iff (!nrst)
    rx_s == $past(rx_meta))
    else $error("rx synchroniser order broken");
endmodule
`default_nettype wire

// File: dv/sla_bus_node.sv
// other node on the shared single-wire bus
// assumes wired-and bus with pull-up; dominant is low
`default_nettype none
module sla_bus_node (
  input  wire logic tx_pin,
  input  wire logic node_tx,
  output logic      rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // either node pulling low wins
  assign rx_pin = tx_pin & node_tx;
endmodule
`default_nettype wire

// File: dv/sla_timer_bench.sv
// self-checking bench for sla_timer
// assumes sla_bus_node closes the rx loop from tx_pin
`default_nettype none
module sla_timer_bench
  import sla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
  logic       clock, nrst, wr, rd, rx_pin, serial_tx_internal;
  logic       prescaler_tick, tx_pin, node_tx;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d, d2;
  int         n_errors, cmp_count, cyc, seed, n;
  sla_timer u_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .serial_tx_internal(serial_tx_internal),
    .prescaler_tick(prescaler_tick), .tx_pin(tx_pin));
  sla_bus_node u_node (.tx_pin(tx_pin), .node_tx(node_tx), .rx_pin(rx_pin));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // prescaler output every other clock
  always @(posedge clock) begin
    prescaler_tick <= ~prescaler_tick;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
    @(posedge clock);
  endtask
  // quantised counts: phase and sync delay allow two counts of slack
  function automatic logic near(input int c, input int ex);
    return (c >= ex - 2) && (c <= ex + 2);
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h7be024ef;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    node_tx = 1'b1;
    serial_tx_internal = 1'b1;
    prescaler_tick = 1'b0;
    tick(20);
    nrst <= 1'b1;
    @(posedge clock);
    rd_reg(OFS_COUNT_LOW, d);
    `CHK("count", RST_BYTE, d)
    rd_reg(OFS_STATUS, d);
    `CHK("status", RST_BYTE, d)
    // bit time, bus clock / 4
    n = 40 + ($random(seed) & 127);
    wr_reg(OFS_CONTROL, {6'h00, MODE_MEASURE});
    tick(4);
    node_tx <= 1'b0;
    tick(8);
    node_tx <= 1'b1;
    tick(n - 10);
    rd_reg(OFS_STATUS, d);
    `CHK("running", 1'b1, d[ST_RUN])
    node_tx <= 1'b0;
    tick(10);
    rd_reg(OFS_STATUS, d);
    `CHK("done", 2'h1, {d[ST_RUN], d[ST_DONE]})
    rd_reg(OFS_COUNT_LOW, d);
    `CHK("bit time", 1'b1, near(d, n / 4))
    tick(12);
    rd_reg(OFS_COUNT_LOW, d2);
    `CHK("held", d, d2)
    // break length, rx already low at enable, wraps the counter
    n = 4200 + ($random(seed) & 127);
    wr_reg(OFS_CONTROL, {5'h00, 1'b1, MODE_MEASURE});
    rd_reg(OFS_STATUS, d);
    `CHK("done clr", 1'b0, d[ST_DONE])
    tick(n - 2);
    node_tx <= 1'b1;
    tick(20);
    rd_reg(OFS_COUNT_LOW, d2);
    rd_reg(OFS_STATUS, d);
    `CHK("break", 1'b1, near({d[ST_TOP], d2}, n / 8 - 512))
    `CHK("ovfl", 2'h1, {d[ST_RUN], d[ST_OVFL]})
    wr_reg(OFS_CONTROL, {6'h00, MODE_IDLE});
    wr_reg(OFS_COUNT_LOW, 8'($random(seed)));
    repeat (10) begin
      node_tx <= ~node_tx;
      tick(4);
    end
    rd_reg(OFS_COUNT_LOW, d);
    `CHK("idle count", RST_BYTE, d)
    rd_reg(OFS_STATUS, d);
    `CHK("cleared", RST_BYTE, d)
    // reserved mode must read back yet stay idle
    wr_reg(OFS_CONTROL, 8'h07);
    rd_reg(OFS_CONTROL, d);
    `CHK("control", 8'h07, d)
    tick(12);
    rd_reg(OFS_STATUS, d);
    `CHK("mode 11 idle", RST_BYTE, d)
    rd_reg(2'h3, d);
    `CHK("spare", RST_BYTE, d)
    // arbitration over both clock selects, with and without a rival
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_CONTROL, {5'h00, k[0], MODE_ARB});
      serial_tx_internal <= 1'b0;
      tick(4);
      serial_tx_internal <= 1'b1;
      node_tx <= ~k[1];
      tick(k[0] ? 50 : 200);
      rd_reg(OFS_STATUS, d);
      `CHK("early", 1'b0, d[ST_LOST])
      tick(40);
      rd_reg(OFS_STATUS, d);
      `CHK("lost", k[1], d[ST_LOST])
      serial_tx_internal <= 1'b0;
      tick(3);
      @(negedge clock);
      `CHK("tx forced", k[1], tx_pin)
      @(posedge clock);
      wr_reg(OFS_CONTROL, {6'h00, MODE_IDLE});
      rd_reg(OFS_STATUS, d);
      `CHK("lost clr", 1'b0, d[ST_LOST])
      @(negedge clock);
      `CHK("tx free", 1'b0, tx_pin)
      @(posedge clock);
      node_tx <= 1'b1;
      serial_tx_internal <= 1'b1;
    end
    print_verdict();
  end
endmodule
`default_nettype wire
